// *** rtl/ims_pkg.sv ***
package ims_pkg;
	// Summary of operation
	// - start request with bus idle enters master operation, sets master flag, sends Start
	// - after Start: event and start-sent flags, SCL held until status read and address write
	// - 7-bit addressing sends one address byte, MSB first
	// - 10-bit header sent: event flag, SCL held until status read and data write
	// - address done and acknowledged: event flag, SCL held until status read, control write
	// - receiver: ack if enabled, then event and byte-done, held until status and data read
	// - stop requested before last data read ends receive, Stop sent, master flag cleared
	// - transmitter shifts data out, holds SCL for status read and data write, flags on ack
	// - stop requested after last data write ends transmit, Stop sent, master cleared
	// - Start or Stop inside a byte sets event and bus-error flags
	// - misplaced condition in pulse one or two: no bus error, transfer goes on, busy reset
	// - nack sets event and ack-failure flags (address nack only with ack enabled); software resumes with Start or Stop
	// - status two read clears ack failure; a nack seen again sets it again
	// - arbitration loss sets its flag, clears master flag, back to slave
	// - error cases do not stretch SCL; hardware releases both lines
	// - wait mode has no effect and enabled events wake the system
	// - halt freezes registers, no bus activity, own events cannot wake it
	// - all nine event sources share one request gated by enable and global mask
	// - slave operation with master flag clear unless running own transfer
	// - start request cleared by hardware when Start sent or block disabled
	// - stop request cleared by hardware when Stop sent

	// ==========================================================
	// bus timing
	localparam int SCL_QTR_NS = 2500;
	localparam int LINK_CLK_NS = 48;
	localparam int QTR_CYC_DEF = (SCL_QTR_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;

	// ==========================================================
	// byte slot layout and address patterns
	localparam logic [4:0] HDR10_CODE = 5'h1e;
	localparam logic [3:0] BCNT_ACK = 4'h8;
	localparam logic [3:0] BCNT_LATE = 4'h2;
	localparam logic [1:0] PH_0 = 2'h0;
	localparam logic [1:0] PH_1 = 2'h1;
	localparam logic [1:0] PH_2 = 2'h2;
	localparam logic [1:0] PH_3 = 2'h3;

	// ==========================================================
	// link commands and results
	typedef enum logic [1:0] {CMD_START, CMD_TX, CMD_RX, CMD_STOP} ims_cmd_t;
	typedef enum logic [1:0] {RES_OK, RES_NACK, RES_ARBITRATION_LOST_FLAG, RES_BUS_ERROR_FLAG} ims_res_t;
endpackage

// *** rtl/ims_link.sv ***
`timescale 1ns/1ps
module ims_link
	import ims_pkg::*;
#(
	parameter int QTR_CYC = QTR_CYC_DEF
) (
	input wire logic i_link_clk,
	input wire logic i_rst_n,
	input wire logic i_freeze,
	input wire logic i_cmd_tgl,
	input wire ims_cmd_t i_cmd,
	input wire logic [7:0] i_cmd_byte,
	input wire logic i_cmd_ack,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_done_tgl,
	output ims_res_t o_res,
	output logic [7:0] o_rx_byte,
	output logic o_busy,
	output logic o_scl_oe,
	output logic o_sda_oe
);
	localparam int QW = $clog2(QTR_CYC + 1);
	typedef enum logic [1:0] {L_IDLE, L_START, L_BIT, L_STOP} ims_lst_t;

	ims_lst_t st_reg;
	logic [1:0] ph_reg;
	logic [3:0] bcnt_reg;
	logic [7:0] sh_reg;
	logic [QW-1:0] qcnt_reg;
	logic rxm_reg, nack_reg, scl_oe_reg, sda_oe_reg;
	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic tgl_s1, tgl_s2, tgl_s3, frz_s1, frz_s2;
	logic tick, stall, cmd_new, start_det, stop_det, misplaced;
	logic abort_arbitration_lost_flag, abort_bus_error_flag, fin;
	ims_res_t res_now;

	// ==========================================================
	// synchronisers; first stages feed only the second
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
			{tgl_s1, tgl_s2, tgl_s3, frz_s1, frz_s2} <= 5'h00;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {i_scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {i_sda, sda_s1, sda_s2};
			{frz_s1, frz_s2} <= {i_freeze, frz_s1};
			{tgl_s1, tgl_s2} <= {i_cmd_tgl, tgl_s1};
			if (!frz_s2) begin
				tgl_s3 <= tgl_s2;
			end
		end
	end

	// bus conditions seen while SCL is high
	assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
	assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
	assign misplaced = (st_reg == L_BIT) && (start_det || stop_det);
	assign cmd_new = (st_reg == L_IDLE) && (tgl_s2 != tgl_s3);
	assign tick = qcnt_reg == QW'(QTR_CYC - 1);
	// a slave stretching SCL stops the high phase from counting
	assign stall = (st_reg == L_BIT) && (ph_reg == PH_2) && !scl_s2;
	assign abort_bus_error_flag = misplaced && (bcnt_reg >= BCNT_LATE);
	assign abort_arbitration_lost_flag = (st_reg == L_BIT) && tick && (ph_reg == PH_2) && !rxm_reg &&
		(bcnt_reg < BCNT_ACK) && !sda_oe_reg && !sda_s2;
	assign fin = abort_bus_error_flag || abort_arbitration_lost_flag || ((st_reg != L_IDLE) && tick && (ph_reg == PH_3) &&
		((st_reg != L_BIT) || (bcnt_reg == BCNT_ACK)));

	// result priority: bus error over arbitration over nack
	always_comb begin
		res_now = RES_OK;
		if (abort_bus_error_flag) begin
			res_now = RES_BUS_ERROR_FLAG;
		end else if (abort_arbitration_lost_flag) begin
			res_now = RES_ARBITRATION_LOST_FLAG;
		end else if (nack_reg) begin
			res_now = RES_NACK;
		end
	end

	// ==========================================================
	// quarter-bit timer
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt_reg <= '0;
		end else if (!frz_s2) begin
			if (st_reg == L_IDLE || tick) begin
				qcnt_reg <= '0;
			end else if (!stall) begin
				qcnt_reg <= qcnt_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// line sequencer; SCL stays low after a Start or an acked byte to stretch the bus
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= L_IDLE;
			ph_reg <= PH_0;
			bcnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			rxm_reg <= 1'b0;
			nack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (!frz_s2) begin
			if (abort_bus_error_flag || abort_arbitration_lost_flag) begin
				st_reg <= L_IDLE;
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end else begin
				case (st_reg)
				L_IDLE: begin
					ph_reg <= PH_0;
					if (cmd_new) begin
						bcnt_reg <= 4'h0;
						sh_reg <= i_cmd_byte;
						rxm_reg <= i_cmd == CMD_RX;
						nack_reg <= 1'b0;
						case (i_cmd)
						CMD_START: st_reg <= L_START;
						CMD_STOP: st_reg <= L_STOP;
						default: st_reg <= L_BIT;
						endcase
					end
				end
				L_START: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					case (ph_reg)
					PH_0: sda_oe_reg <= 1'b0;
					PH_1: scl_oe_reg <= 1'b0;
					PH_2: sda_oe_reg <= 1'b1;
					default: begin
						scl_oe_reg <= 1'b1;
						st_reg <= L_IDLE;
					end
					endcase
				end
				L_STOP: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					case (ph_reg)
					PH_0: scl_oe_reg <= 1'b1;
					PH_1: sda_oe_reg <= 1'b1;
					PH_2: scl_oe_reg <= 1'b0;
					default: begin
						sda_oe_reg <= 1'b0;
						st_reg <= L_IDLE;
					end
					endcase
				end
				default: if (tick) begin
					ph_reg <= ph_reg + 2'h1;
					case (ph_reg)
					PH_0: begin
						if (bcnt_reg == BCNT_ACK) begin
							sda_oe_reg <= rxm_reg && i_cmd_ack;
						end else begin
							sda_oe_reg <= !rxm_reg && !sh_reg[7];
						end
					end
					PH_1: scl_oe_reg <= 1'b0;
					PH_2: begin
						if (bcnt_reg == BCNT_ACK) begin
							nack_reg <= !rxm_reg && sda_s2;
						end else begin
							sh_reg <= {sh_reg[6:0], sda_s2};
						end
					end
					default: begin
						// sda stays put while scl falls; it only moves in the low quarter
						if (bcnt_reg == BCNT_ACK) begin
							scl_oe_reg <= !nack_reg;
							st_reg <= L_IDLE;
						end else begin
							scl_oe_reg <= 1'b1;
							bcnt_reg <= bcnt_reg + 4'h1;
						end
					end
					endcase
				end
				endcase
			end
		end
	end

	// ==========================================================
	// results held stable until the next command
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done_tgl <= 1'b0;
			o_res <= RES_OK;
			o_rx_byte <= 8'h00;
		end else if (!frz_s2 && fin) begin
			o_done_tgl <= !o_done_tgl;
			o_res <= res_now;
			o_rx_byte <= sh_reg;
		end
	end

	// bus busy between Start and Stop
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy <= 1'b0;
		end else if (!frz_s2) begin
			if (misplaced && bcnt_reg < BCNT_LATE) begin
				o_busy <= 1'b0;
			end else if (start_det) begin
				o_busy <= 1'b1;
			end else if (stop_det) begin
				o_busy <= 1'b0;
			end
		end
	end

	// halted: lines let go, nothing acknowledged
	assign o_scl_oe = scl_oe_reg && !frz_s2;
	assign o_sda_oe = sda_oe_reg && !frz_s2;
endmodule

// *** rtl/ims_master_seq.sv ***
`timescale 1ns/1ps
module ims_master_seq
	import ims_pkg::*;
#(
	parameter int QTR_CYC = QTR_CYC_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_link_clk,
	input wire logic i_enable,
	input wire logic i_addr10,
	input wire logic i_ack_enable,
	input wire logic i_irq_enable,
	input wire logic i_irq_mask,
	input wire logic i_halt,
	input wire logic i_cr_wr,
	input wire logic i_cr_start,
	input wire logic i_cr_stop,
	input wire logic i_sr1_rd,
	input wire logic i_sr2_rd,
	input wire logic i_dr_rd,
	input wire logic i_dr_wr,
	input wire logic [7:0] i_dr_wdata,
	input wire logic i_address_match,
	input wire logic i_stop_seen,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic [7:0] o_dr_rdata,
	output logic o_master,
	output logic o_event,
	output logic o_start_sent,
	output logic o_header_sent,
	output logic o_byte_done,
	output logic o_ack_fail,
	output logic o_arb_lost,
	output logic o_bus_error,
	output logic o_busy,
	output logic o_start_req,
	output logic o_stop_req,
	output logic o_irq,
	output logic o_scl_o,
	output logic o_scl_oe,
	output logic o_sda_o,
	output logic o_sda_oe
);
	typedef enum logic [3:0] {
		C_SLAVE, C_GO_START, C_SB, C_ADDR, C_HDR, C_ADDR2, C_EV6,
		C_TXW, C_TX, C_TXEV, C_RX, C_RXEV, C_AF, C_STOP
	} ims_cst_t;

	// ==========================================================
	// elaboration check
	if (QTR_CYC < 4) begin : g_qtr_chk
		$error("QTR_CYC must cover the synchroniser latency");
	end

	ims_cst_t state_reg, state_next;
	ims_cmd_t cmd_reg, cmd_next;
	ims_res_t link_res;
	logic [7:0] cmd_byte_reg, cmd_byte_next, link_rx;
	logic cmd_tgl_reg, cmd_ack_reg, go, link_done_tgl, link_busy;
	logic master_next, dir_rx_reg, dir_rx_next, hdr_wr_reg, hdr_wr_next;
	logic done_s1, done_s2, done_s3, busy_s1, busy_s2, freeze_reg;
	logic ce, done_new, res_ok, res_nack, lost, wait_st, acc_done, leave;
	logic sr1_seen_reg, ev6_reg, is_hdr_wr, start_now;

	// halt freezes every register on this side except freeze_reg
	assign ce = i_ce && !i_halt;

	// ==========================================================
	// crossings from the link side
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{done_s1, done_s2, done_s3} <= 3'h0;
			{busy_s1, busy_s2} <= 2'h0;
		end else if (ce) begin
			{done_s1, done_s2, done_s3} <= {link_done_tgl, done_s1, done_s2};
			{busy_s1, busy_s2} <= {link_busy, busy_s1};
		end
	end

	// freeze level for the link side, never gated itself
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			freeze_reg <= 1'b0;
		end else begin
			freeze_reg <= !ce;
		end
	end

	// result and byte are stable once the toggle edge is seen
	assign done_new = done_s2 != done_s3;
	assign res_ok = done_new && link_res == RES_OK;
	assign res_nack = done_new && link_res == RES_NACK;
	assign lost = done_new && (link_res == RES_ARBITRATION_LOST_FLAG || link_res == RES_BUS_ERROR_FLAG);
	assign is_hdr_wr = i_addr10 && i_dr_wdata[7:3] == HDR10_CODE && !i_dr_wdata[0];
	assign wait_st = state_reg inside {C_SB, C_HDR, C_EV6, C_TXEV, C_RXEV};
	assign leave = state_next != state_reg;
	// the control write that ends an event wait may itself ask for the repeated start
	assign start_now = o_start_req || (i_cr_wr && i_cr_start);

	// ==========================================================
	// last access of each waiting sequence
	always_comb begin
		case (state_reg)
		C_SB, C_HDR, C_TXEV: acc_done = sr1_seen_reg && i_dr_wr;
		C_EV6: acc_done = sr1_seen_reg && i_cr_wr;
		C_RXEV: acc_done = sr1_seen_reg && i_dr_rd;
		default: acc_done = 1'b0;
		endcase
	end

	// ==========================================================
	// transfer sequencing and link commands
	always_comb begin
		state_next = state_reg;
		master_next = o_master;
		dir_rx_next = dir_rx_reg;
		hdr_wr_next = hdr_wr_reg;
		go = 1'b0;
		cmd_next = cmd_reg;
		cmd_byte_next = cmd_byte_reg;
		if (!i_enable) begin
			state_next = C_SLAVE;
			master_next = 1'b0;
		end else if (lost) begin
			state_next = C_SLAVE;
			master_next = 1'b0;
		end else begin
			case (state_reg)
			C_SLAVE: if (o_start_req && !busy_s2) begin
				state_next = C_GO_START;
				master_next = 1'b1;
				go = 1'b1;
				cmd_next = CMD_START;
			end
			C_GO_START: if (done_new) begin
				state_next = C_SB;
			end
			C_SB: if (o_stop_req) begin
				state_next = C_STOP;
				go = 1'b1;
				cmd_next = CMD_STOP;
			end else if (acc_done) begin
				state_next = C_ADDR;
				go = 1'b1;
				cmd_next = CMD_TX;
				cmd_byte_next = i_dr_wdata;
				dir_rx_next = i_dr_wdata[0];
				hdr_wr_next = is_hdr_wr;
			end
			C_ADDR, C_ADDR2: if (res_nack && i_ack_enable) begin
				state_next = C_AF;
			end else if (done_new) begin
				state_next = (state_reg == C_ADDR && hdr_wr_reg) ? C_HDR : C_EV6;
			end
			C_HDR: if (acc_done) begin
				state_next = C_ADDR2;
				go = 1'b1;
				cmd_next = CMD_TX;
				cmd_byte_next = i_dr_wdata;
			end
			C_EV6, C_TXEV, C_RXEV: if (acc_done && start_now) begin
				state_next = C_GO_START;
				go = 1'b1;
				cmd_next = CMD_START;
			end else if (acc_done && o_stop_req && state_reg == C_RXEV) begin
				state_next = C_STOP;
				go = 1'b1;
				cmd_next = CMD_STOP;
			end else if (acc_done && (state_reg == C_RXEV || dir_rx_reg && state_reg == C_EV6)) begin
				state_next = C_RX;
				go = 1'b1;
				cmd_next = CMD_RX;
			end else if (acc_done && state_reg == C_EV6) begin
				state_next = C_TXW;
			end else if (acc_done) begin
				state_next = C_TX;
				go = 1'b1;
				cmd_next = CMD_TX;
				cmd_byte_next = i_dr_wdata;
			end
			C_TXW: if (i_dr_wr) begin
				state_next = C_TX;
				go = 1'b1;
				cmd_next = CMD_TX;
				cmd_byte_next = i_dr_wdata;
			end else if (o_stop_req) begin
				state_next = C_STOP;
				go = 1'b1;
				cmd_next = CMD_STOP;
			end
			C_TX: if (res_nack) begin
				state_next = C_AF;
			end else if (done_new && o_stop_req) begin
				state_next = C_STOP;
				go = 1'b1;
				cmd_next = CMD_STOP;
			end else if (done_new) begin
				state_next = C_TXEV;
			end
			C_RX: if (done_new) begin
				state_next = C_RXEV;
			end
			C_AF: if (o_start_req) begin
				state_next = C_GO_START;
				go = 1'b1;
				cmd_next = CMD_START;
			end else if (o_stop_req) begin
				state_next = C_STOP;
				go = 1'b1;
				cmd_next = CMD_STOP;
			end
			default: if (done_new) begin
				state_next = C_SLAVE;
				master_next = 1'b0;
			end
			endcase
		end
	end

	// state and command registers; the toggle hands the command across
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= C_SLAVE;
			o_master <= 1'b0;
			dir_rx_reg <= 1'b0;
			hdr_wr_reg <= 1'b0;
			cmd_reg <= CMD_START;
			cmd_byte_reg <= 8'h00;
			cmd_tgl_reg <= 1'b0;
			cmd_ack_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			o_master <= master_next;
			dir_rx_reg <= dir_rx_next;
			hdr_wr_reg <= hdr_wr_next;
			cmd_reg <= cmd_next;
			cmd_byte_reg <= cmd_byte_next;
			if (go) begin
				cmd_tgl_reg <= !cmd_tgl_reg;
				cmd_ack_reg <= i_ack_enable;
			end
		end
	end

	// status one must be read before the finishing access counts
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr1_seen_reg <= 1'b0;
		end else if (ce) begin
			sr1_seen_reg <= wait_st && !leave && (sr1_seen_reg || i_sr1_rd);
		end
	end

	// ==========================================================
	// start and stop requests; a software write wins over the hardware clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_start_req <= 1'b0;
			o_stop_req <= 1'b0;
		end else if (ce) begin
			if (i_cr_wr) begin
				o_start_req <= i_cr_start && i_enable;
				o_stop_req <= i_cr_stop;
			end else begin
				if (!i_enable || state_reg == C_GO_START && res_ok) begin
					o_start_req <= 1'b0;
				end
				if (state_reg == C_STOP && done_new) begin
					o_stop_req <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// event flags; hardware set wins over the access clears, disable clears all
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_start_sent <= 1'b0;
			o_header_sent <= 1'b0;
			ev6_reg <= 1'b0;
			o_byte_done <= 1'b0;
			o_ack_fail <= 1'b0;
			o_arb_lost <= 1'b0;
			o_bus_error <= 1'b0;
		end else if (ce) begin
			if (!i_enable) begin
				{o_start_sent, o_header_sent, ev6_reg, o_byte_done} <= 4'h0;
				{o_ack_fail, o_arb_lost, o_bus_error} <= 3'h0;
			end else begin
				o_start_sent <= (state_reg == C_GO_START && res_ok) ||
					(o_start_sent && !(state_reg == C_SB && leave));
				o_header_sent <= (state_next == C_HDR && leave) ||
					(o_header_sent && !(state_reg == C_HDR && leave));
				ev6_reg <= (state_next == C_EV6 && leave) ||
					(ev6_reg && !(state_reg == C_EV6 && leave));
				o_byte_done <= (state_next inside {C_TXEV, C_RXEV} && leave) ||
					(o_byte_done && !(state_reg inside {C_TXEV, C_RXEV} && leave));
				o_ack_fail <= (state_next == C_AF && leave) ||
					(o_ack_fail && !i_sr2_rd);
				o_arb_lost <= (done_new && link_res == RES_ARBITRATION_LOST_FLAG && o_master) ||
					(o_arb_lost && !i_sr2_rd);
				o_bus_error <= (done_new && link_res == RES_BUS_ERROR_FLAG && o_master) ||
					(o_bus_error && !i_sr2_rd);
			end
		end
	end

	// data register: software writes, received bytes land here
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dr_rdata <= 8'h00;
		end else if (ce) begin
			if (i_dr_wr) begin
				o_dr_rdata <= i_dr_wdata;
			end else if (state_reg == C_RX && res_ok) begin
				o_dr_rdata <= link_rx;
			end
		end
	end

	// ==========================================================
	// shared request; wait mode does not gate it so it can wake the system
	assign o_event = |{o_start_sent, o_header_sent, ev6_reg, o_byte_done, o_ack_fail,
		o_arb_lost, o_bus_error, i_address_match, i_stop_seen};
	assign o_irq = o_event && i_irq_enable && !i_irq_mask;
	assign o_busy = busy_s2;
	assign o_scl_o = 1'b0; // open drain: only ever pulls low
	assign o_sda_o = 1'b0;

	// ==========================================================
	// line engine on the link clock
	ims_link #(
		.QTR_CYC(QTR_CYC)
	) u_link (
		.i_link_clk(i_link_clk),
		.i_rst_n(i_rst_n),
		.i_freeze(freeze_reg),
		.i_cmd_tgl(cmd_tgl_reg),
		.i_cmd(cmd_reg),
		.i_cmd_byte(cmd_byte_reg),
		.i_cmd_ack(cmd_ack_reg),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_done_tgl(link_done_tgl),
		.o_res(link_res),
		.o_rx_byte(link_rx),
		.o_busy(link_busy),
		.o_scl_oe(o_scl_oe),
		.o_sda_oe(o_sda_oe)
	);
endmodule

// *** test/ims_master_seq_sva.sv ***
`timescale 1ns/1ps
module ims_master_seq_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_enable,
	input wire logic i_irq_enable,
	input wire logic i_irq_mask,
	input wire logic i_halt,
	input wire logic i_sr1_rd,
	input wire logic i_sr2_rd,
	input wire logic i_dr_wr,
	input wire logic [7:0] o_dr_rdata,
	input wire logic o_master,
	input wire logic o_event,
	input wire logic o_start_sent,
	input wire logic o_byte_done,
	input wire logic o_ack_fail,
	input wire logic o_arb_lost,
	input wire logic o_start_req,
	input wire logic o_stop_req,
	input wire logic o_irq,
	input wire logic o_scl_oe
);
	// ==========================================================
	// checks on the register side
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic go;
	// strobes only count while running and not halted
	assign go = i_ce && !i_halt;
	property p_irq; o_irq == (o_event && i_irq_enable && !i_irq_mask); endproperty
	a_irq: assert property (p_irq) else $error("irq gating wrong");
	property p_sb; $rose(o_start_sent) |-> o_master && !o_start_req; endproperty
	a_sb: assert property (p_sb) else $error("start sent without master");
	property p_sb_hold; $rose(o_start_sent) |-> o_scl_oe; endproperty
	a_sb_hold: assert property (p_sb_hold) else $error("scl not held after start");
	property p_bd_hold; $rose(o_byte_done) |-> o_scl_oe && o_master; endproperty
	a_bd_hold: assert property (p_bd_hold) else $error("scl not held at byte end");
	property p_dis; go && !i_enable |=> !o_start_req && !o_master; endproperty
	a_dis: assert property (p_dis) else $error("disable left request");
	property p_halt; i_halt |=> $stable(o_master) && $stable(o_dr_rdata) && $stable(o_start_req);
	endproperty
	a_halt: assert property (p_halt) else $error("state moved in halt");
	property p_af; go && i_sr2_rd && o_ack_fail |=> !o_ack_fail; endproperty
	a_af: assert property (p_af) else $error("ack fail not cleared");
	property p_stop; $fell(o_master) && i_enable && !o_arb_lost |-> !o_stop_req; endproperty
	a_stop: assert property (p_stop) else $error("stop request left set");
	property p_adr; go && o_start_sent && i_sr1_rd ##1 go && i_dr_wr |=> !o_start_sent && !o_event;
	endproperty
	a_adr: assert property (p_adr) else $error("event not cleared by access");
	c_sb: cover property ($rose(o_start_sent));
	c_bd: cover property ($rose(o_byte_done));
	c_af: cover property ($rose(o_ack_fail));
endmodule

// *** test/ims_slave_model.sv ***
`timescale 1ns/1ps
module ims_slave_model #(
	parameter logic [7:0] RD_BYTE = 8'h96
) (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_nack,
	output logic o_sda_oe,
	output logic [7:0] o_rx_byte
);
	// ==========================================================
	// behavioural slave, never stretches the clock
	logic [7:0] sh_reg = 8'h00;
	int cnt = 0;
	logic adr_ph = 0;
	logic rd_mode = 0;
	initial o_sda_oe = 0;
	initial o_rx_byte = 8'h00;
	// start or repeated start opens an address byte
	always @(negedge i_sda) if (i_scl) begin
		cnt = 0;
		adr_ph = 1;
		rd_mode = 0;
	end
	// stop ends the frame and frees the line
	always @(posedge i_sda) if (i_scl) begin
		cnt = 0;
		rd_mode = 0;
		o_sda_oe = 0;
	end
	always @(posedge i_scl) begin
		if (cnt < 8) sh_reg = {sh_reg[6:0], i_sda};
		if (cnt == 8 && rd_mode && !adr_ph && i_sda) rd_mode = 0; // master nack ends read
		cnt++;
	end
	// data changes only while scl is low
	always @(negedge i_scl) begin
		if (cnt == 8) begin
			o_rx_byte = sh_reg;
			if (adr_ph) rd_mode = sh_reg[0] && !i_nack; // a refused address starts no read
			o_sda_oe = (adr_ph || !rd_mode) && !i_nack;
		end else begin
			if (cnt == 9) begin
				cnt = 0;
				adr_ph = 0;
			end
			o_sda_oe = rd_mode && !adr_ph && cnt < 8 && !RD_BYTE[7 - cnt];
		end
	end
endmodule

// *** test/ims_master_seq_tb.sv ***
`timescale 1ns/1ps
module ims_master_seq_tb;
	logic i_clk = 0, i_link_clk = 0, i_rst_n = 0, i_ce = 1, i_enable = 0, i_addr10 = 0;
	logic i_ack_enable = 1, i_irq_enable = 1, i_irq_mask = 0, i_halt = 0, i_cr_wr = 0;
	logic i_cr_start = 0, i_cr_stop = 0, i_sr1_rd = 0, i_sr2_rd = 0, i_dr_rd = 0, i_dr_wr = 0;
	logic i_address_match = 0, i_stop_seen = 0, nk = 0, ssoe;
	logic [7:0] i_dr_wdata = 8'h00, o_dr_rdata, srx;
	logic o_master, o_event, o_start_sent, o_header_sent, o_byte_done, o_ack_fail, o_arb_lost;
	logic o_bus_error, o_busy, o_start_req, o_stop_req, o_irq, o_scl_o, o_scl_oe, o_sda_o;
	logic o_sda_oe;
	int num_errors = 0, checks = 0, cyc = 0;
	// open-drain wires with pull-ups
	wire i_scl = ~o_scl_oe;
	wire i_sda = ~(o_sda_oe | ssoe);
	// ==========================================================
	// clocks, design and far side
	always #2.5 i_clk = ~i_clk;
	always #24 i_link_clk = ~i_link_clk;
	ims_master_seq #(.QTR_CYC(4)) dut_u (.*);
	ims_slave_model slv_u (.i_scl(i_scl), .i_sda(i_sda), .i_nack(nk), .o_sda_oe(ssoe),
		.o_rx_byte(srx));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// cut a hang short
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 60000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one-cycle access: 0 sr1, 1 dr write, 2 dr read, 3 control write, 4 sr2
	task automatic acc(input int k, input logic [7:0] d = 8'h00);
		case (k)
			0: i_sr1_rd = 1;
			1: {i_dr_wr, i_dr_wdata} = {1'b1, d};
			2: i_dr_rd = 1;
			3: {i_cr_wr, i_cr_start, i_cr_stop} = {1'b1, d[1:0]};
			default: i_sr2_rd = 1;
		endcase
		@(posedge i_clk);
		#1;
		// drop only the strobe raised, so a following call sets each signal once
		case (k)
			0: i_sr1_rd = 0;
			1: i_dr_wr = 0;
			2: i_dr_rd = 0;
			3: i_cr_wr = 0;
			default: i_sr2_rd = 0;
		endcase
	endtask
	// m=0 waits for an event, m=1 for the bus to be free again
	task automatic wt(input bit m);
		int n;
		n = 0;
		while ((m ? (o_master | o_busy) : !o_event) !== 1'b0 && n < 9000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk({7'h0, n < 9000}, 8'h01);
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		#1;
		i_rst_n = 1;
		i_enable = 1;
		repeat (3) @(posedge i_clk);
		#1;
		chk({6'h0, o_master, o_start_req}, 8'h00);
		acc(3, 8'h02);
		wt(0);
		chk({4'h0, o_master, o_start_sent, o_start_req, o_irq}, 8'h0d);
		i_irq_mask = 1;
		@(posedge i_clk);
		#1;
		chk({7'h0, o_irq}, 8'h00);
		i_irq_mask = 0;
		acc(0);
		acc(1, 8'ha0);
		chk({7'h0, o_event}, 8'h00);
		wt(0);
		chk(srx, 8'ha0);
		acc(0);
		acc(3, 8'h00);
		acc(0);
		acc(1, 8'h5a);
		wt(0);
		chk({7'h0, o_byte_done}, 8'h01);
		chk({7'h0, o_busy}, 8'h01);
		chk(srx, 8'h5a);
		acc(0);
		acc(1, 8'h3c);
		acc(3, 8'h01);
		wt(1);
		chk(srx, 8'h3c);
		chk({6'h0, o_master, o_stop_req}, 8'h00);
		// master read of two bytes, nack on the last
		acc(3, 8'h02);
		wt(0);
		acc(0);
		acc(1, 8'ha1);
		wt(0);
		acc(0);
		acc(3, 8'h00);
		wt(0);
		chk({6'h0, o_byte_done, o_master}, 8'h03);
		chk(o_dr_rdata, 8'h96);
		acc(0);
		i_ack_enable = 0;
		acc(2);
		wt(0);
		acc(0);
		acc(3, 8'h01);
		acc(2);
		wt(1);
		chk({6'h0, o_master, o_stop_req}, 8'h00);
		chk(o_dr_rdata, 8'h96);
		// ten-bit header, then repeated start and a refused address
		i_ack_enable = 1;
		i_addr10 = 1;
		acc(3, 8'h02);
		wt(0);
		acc(0);
		acc(1, 8'hf0);
		wt(0);
		chk({7'h0, o_header_sent}, 8'h01);
		acc(0);
		acc(1, 8'h55);
		wt(0);
		chk(srx, 8'h55);
		nk = 1;
		acc(0);
		acc(3, 8'h02);
		wt(0);
		acc(0);
		acc(1, 8'hf1);
		wt(0);
		chk({6'h0, o_ack_fail, o_event}, 8'h03);
		acc(4);
		chk({7'h0, o_ack_fail}, 8'h00);
		chk({6'h0, o_arb_lost, o_bus_error}, 8'h00);
		acc(3, 8'h01);
		wt(1);
		nk = 0;
		// halt freezes requests, disable refuses them
		i_halt = 1;
		acc(3, 8'h02);
		chk({7'h0, o_start_req}, 8'h00);
		i_halt = 0;
		i_enable = 0;
		@(posedge i_clk);
		#1;
		acc(3, 8'h02);
		chk({6'h0, o_start_req, o_master}, 8'h00);
		tally_and_finish();
	end
endmodule
bind ims_master_seq ims_master_seq_chk chk_u (.*);
